// [src/bpbus_defines.svh]
// constants for the backplane device bus slave
`ifndef BPBUS_DEFINES_SVH
`define BPBUS_DEFINES_SVH
`define BPBUS_DATA_W 8
`define BPBUS_ADDR_W 10
`define BPBUS_NUM_DEV 16
`define BPBUS_NUM_MEM 4
`define BPBUS_REG_CTRL 10'h000
`define BPBUS_REG_STAT 10'h000
`define BPBUS_REG_AUX 10'h001
`define BPBUS_STAT_ALERT_BIT 7
`define BPBUS_STAT_ALARM_BIT 1
`define BPBUS_STAT_DONE_BIT 0
`define BPBUS_CTRL_CLR_DONE_BIT 0
`define BPBUS_CTRL_ALERT_EN_BIT 7
`define BPBUS_CTRL_RESET 8'h80
`define BPBUS_MEM_DEPTH 64
`endif

// [src/bpbus_pkg.sv]
// types for the backplane device bus slave
package bpbus_pkg;
  typedef enum logic [1:0] {BPBUS_IDLE, BPBUS_WRITE, BPBUS_READ} bpbus_cyc_t;
endpackage

// [src/bpbus_slave.sv]
// board-side slave of the backplane device bus
`timescale 1ns/1ps
`include "bpbus_defines.svh"
module bpbus_slave
  import bpbus_pkg::*;
#(
  parameter int DEV_ID = 0,
  parameter int MEM_ID = 0,
  parameter int MEM_DEPTH = `BPBUS_MEM_DEPTH
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  // backplane bus pins
  input wire logic [`BPBUS_ADDR_W-1:0] bus_addr,
  input wire logic [`BPBUS_DATA_W-1:0] bus_data_in,
  output logic [`BPBUS_DATA_W-1:0] bus_data_out,
  output logic bus_data_oe,
  input wire logic bus_read_write,
  input wire logic bus_strobe_n,
  input wire logic [`BPBUS_NUM_DEV-1:0] device_select_n,
  input wire logic [`BPBUS_NUM_MEM-1:0] memory_select_n,
  input wire logic bus_reset_n,
  output logic fast_alert_request_n,
  output logic fast_alert_request_oe,
  output logic board_fitted_n,
  output logic board_fitted_oe,
  // board events and state
  input wire logic op_done,
  input wire logic alarm_event,
  input wire logic [`BPBUS_DATA_W-1:0] aux_status,
  output logic [`BPBUS_DATA_W-1:0] control_out
);
  localparam int AW = `BPBUS_ADDR_W;
  localparam int DW = `BPBUS_DATA_W;
  localparam int MW = $clog2(MEM_DEPTH);

  // ****************************************
  // reset release and pin synchronisers
  // ****************************************
  logic [1:0] rst_pipe;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'h1};
  end
  assign rst_n = rst_pipe[1];

  localparam int SW = AW + DW + 1 + 1 + 1 + 1 + 1;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_s;
  logic [AW-1:0] s_addr;
  logic [DW-1:0] s_data;
  logic s_rw;
  logic s_strobe_n;
  logic s_dev_n;
  logic s_mem_n;
  logic s_breset_n;
  assign pin_raw = {bus_addr, bus_data_in, bus_read_write, bus_strobe_n,
                    device_select_n[DEV_ID], memory_select_n[MEM_ID], bus_reset_n};
  assign {s_addr, s_data, s_rw, s_strobe_n, s_dev_n, s_mem_n, s_breset_n} = pin_s;

  bpbus_sync #(.W(SW), .INIT({{(AW + DW + 1){1'b0}}, 4'hF})) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d(pin_raw),
    .q(pin_s)
  );

  // ****************************************
  // cycle decode
  // ****************************************
  logic dev_sel;
  logic mem_sel;
  logic strobe_low;
  logic strobe_rise;
  logic strobe_prev;
  // a cycle starts, and read data is driven, only while its own select and the strobe are low
  assign dev_sel = !s_dev_n;
  assign mem_sel = !s_mem_n;
  assign strobe_low = !s_strobe_n;
  assign strobe_rise = !strobe_prev && s_strobe_n;

  // ****************************************
  // register and memory state
  // ****************************************
  logic [DW-1:0] ctrl;
  logic [DW-1:0] next_ctrl;
  logic done_flag;
  logic next_done_flag;
  logic alarm_flag;
  logic next_alarm_flag;
  logic [DW-1:0] mem [MEM_DEPTH];
  logic [DW-1:0] next_mem [MEM_DEPTH];
  logic [AW-1:0] cyc_addr;
  logic [AW-1:0] next_cyc_addr;
  logic cyc_dev;
  logic next_cyc_dev;
  logic cyc_mem;
  logic next_cyc_mem;
  logic [DW-1:0] cyc_data;
  logic [DW-1:0] next_cyc_data;
  bpbus_cyc_t cyc;
  bpbus_cyc_t next_cyc;
  logic [DW-1:0] status_word;
  logic [DW-1:0] rd_word;
  logic alert;

  assign alert = (done_flag || alarm_flag) && ctrl[`BPBUS_CTRL_ALERT_EN_BIT];

  always_comb
  begin
    status_word = '0;
    status_word[`BPBUS_STAT_ALERT_BIT] = alert;
    status_word[`BPBUS_STAT_ALARM_BIT] = alarm_flag;
    status_word[`BPBUS_STAT_DONE_BIT] = done_flag;
    rd_word = '0;
    if (mem_sel)
      rd_word = mem[s_addr[MW-1:0]];
    else if (s_addr == `BPBUS_REG_STAT)
      rd_word = status_word;
    else if (s_addr == `BPBUS_REG_AUX)
      rd_word = aux_status;
  end

  always_comb
  begin
    next_cyc = cyc;
    next_cyc_addr = cyc_addr;
    next_cyc_dev = cyc_dev;
    next_cyc_mem = cyc_mem;
    next_cyc_data = cyc_data;
    next_ctrl = ctrl;
    next_mem = mem;
    next_done_flag = done_flag;
    next_alarm_flag = alarm_flag;
    case (cyc)
      BPBUS_IDLE:
      begin
        if (strobe_low && (dev_sel || mem_sel))
          next_cyc = s_rw ? BPBUS_READ : BPBUS_WRITE;
      end
      BPBUS_WRITE:
      begin
        // latch address, data and target while the strobe is low
        if (strobe_low)
        begin
          next_cyc_addr = s_addr;
          next_cyc_data = s_data;
          next_cyc_dev = dev_sel;
          next_cyc_mem = mem_sel;
        end
        else
        begin
          next_cyc = BPBUS_IDLE;
          // commit on the rising strobe edge
          if (strobe_rise && cyc_mem)
            next_mem[cyc_addr[MW-1:0]] = cyc_data;
          else if (strobe_rise && cyc_dev && cyc_addr == `BPBUS_REG_CTRL)
          begin
            next_ctrl = cyc_data;
            if (cyc_data[`BPBUS_CTRL_CLR_DONE_BIT])
              next_done_flag = 1'b0;
          end
        end
      end
      BPBUS_READ:
      begin
        if (!strobe_low)
          next_cyc = BPBUS_IDLE;
      end
      default:
        next_cyc = BPBUS_IDLE;
    endcase
    // events win over clears
    if (op_done)
      next_done_flag = 1'b1;
    if (!s_breset_n)
      next_alarm_flag = 1'b0;
    if (alarm_event)
      next_alarm_flag = 1'b1;
  end

  // ****************************************
  // pin drivers
  // ****************************************
  logic [DW-1:0] next_bus_data_out;
  logic next_bus_data_oe;
  logic next_alert_oe;
  logic next_fitted_oe;
  always_comb
  begin
    next_bus_data_oe = strobe_low && s_rw && (dev_sel || mem_sel);
    next_bus_data_out = next_bus_data_oe ? rd_word : '0;
    next_alert_oe = alert;
    next_fitted_oe = dev_sel;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cyc <= BPBUS_IDLE;
      cyc_addr <= '0;
      cyc_dev <= 1'b0;
      cyc_mem <= 1'b0;
      cyc_data <= '0;
      ctrl <= `BPBUS_CTRL_RESET;
      done_flag <= 1'b0;
      alarm_flag <= 1'b0;
      strobe_prev <= 1'b1;
      bus_data_out <= '0;
      bus_data_oe <= 1'b0;
      fast_alert_request_oe <= 1'b0;
      board_fitted_oe <= 1'b0;
      for (int i = 0; i < MEM_DEPTH; i++)
        mem[i] <= '0;
    end
    else if (clk_en)
    begin
      cyc <= next_cyc;
      cyc_addr <= next_cyc_addr;
      cyc_dev <= next_cyc_dev;
      cyc_mem <= next_cyc_mem;
      cyc_data <= next_cyc_data;
      ctrl <= next_ctrl;
      done_flag <= next_done_flag;
      alarm_flag <= next_alarm_flag;
      strobe_prev <= s_strobe_n;
      bus_data_out <= next_bus_data_out;
      bus_data_oe <= next_bus_data_oe;
      fast_alert_request_oe <= next_alert_oe;
      board_fitted_oe <= next_fitted_oe;
      mem <= next_mem;
    end
  end

  // open-drain lines only ever pull low
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fast_alert_request_n <= 1'b0;
      board_fitted_n <= 1'b0;
      control_out <= `BPBUS_CTRL_RESET;
    end
    else if (clk_en)
    begin
      fast_alert_request_n <= 1'b0;
      board_fitted_n <= 1'b0;
      control_out <= next_ctrl;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence seq_read_window;
    strobe_low && s_rw && (dev_sel || mem_sel);
  endsequence

  a_read_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en and seq_read_window) |=> bus_data_oe)
    else $error("read data not driven");
  a_no_idle_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !strobe_low |=> !bus_data_oe)
    else $error("data driven outside strobe");
  a_fitted_sel: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en |=> board_fitted_oe == $past(dev_sel))
    else $error("presence does not follow select");
  a_alert_line: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && alert |=> fast_alert_request_oe)
    else $error("alert not pulled");
  a_alarm_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !s_breset_n && !alarm_event |=> !alarm_flag)
    else $error("bus reset did not clear alarm");
  a_alarm_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && alarm_event |=> alarm_flag)
    else $error("alarm event lost");
  a_alert_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en and seq_read_window) ##0 (dev_sel && !mem_sel && s_addr == `BPBUS_REG_STAT)
      |=> bus_data_out[`BPBUS_STAT_ALERT_BIT] == $past(alert))
    else $error("status alert bit wrong");
  a_ctrl_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && cyc == BPBUS_WRITE && !strobe_low && cyc_dev && !cyc_mem
      && cyc_addr == `BPBUS_REG_CTRL |=> ctrl == $past(cyc_data))
    else $error("control write not captured");
endmodule

// [src/bpbus_sync.sv]
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module bpbus_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb
  begin
    next_meta = clk_en ? d : meta;
    next_q = clk_en ? meta : q;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= INIT;
      q <= INIT;
    end
    else
    begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule

// [verif/bpbus_master.sv]
// bus master model that runs strobed cycles on the backplane bus
`timescale 1ns/1ps
`include "bpbus_defines.svh"
module bpbus_master #(
  parameter int DEV_ID = 0,
  parameter int MEM_ID = 0
) (
  // clock
  input wire logic clk_sys,
  // master-driven bus lines
  output logic [`BPBUS_ADDR_W-1:0] bus_addr,
  output logic [`BPBUS_DATA_W-1:0] bus_data_in,
  output logic bus_read_write,
  output logic bus_strobe_n,
  output logic [`BPBUS_NUM_DEV-1:0] device_select_n,
  output logic [`BPBUS_NUM_MEM-1:0] memory_select_n,
  output logic bus_reset_n
);
  // ****************
  // bus cycles
  // ****************
  initial
  begin
    bus_addr = '0;
    bus_data_in = '0;
    bus_read_write = 1'b1;
    bus_strobe_n = 1'b1;
    device_select_n = '1;
    memory_select_n = '1;
    bus_reset_n = 1'b1;
  end

  // foreign picks the next board's select instead of ours
  task automatic cycle(input logic mem, input logic foreign, input logic rd,
                       input logic [`BPBUS_ADDR_W-1:0] addr,
                       input logic [`BPBUS_DATA_W-1:0] wd);
    @(negedge clk_sys);
    bus_addr = addr;
    bus_read_write = rd;
    bus_data_in = rd ? ~bus_data_in : wd;
    if (mem)
      memory_select_n[MEM_ID] = 1'b0;
    else
      device_select_n[foreign ? (DEV_ID + 1) % 16 : DEV_ID] = 1'b0;
    // a settle cycle keeps the strobe behind the address
    @(negedge clk_sys);
    bus_strobe_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    bus_strobe_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    // released lines flip so that no stale value can pass as valid
    device_select_n = '1;
    memory_select_n = '1;
    bus_data_in = ~bus_data_in;
    bus_addr = ~bus_addr;
    repeat (2) @(negedge clk_sys);
  endtask

  // long enough to pass the board's synchroniser
  task automatic bus_rst;
    @(negedge clk_sys);
    bus_reset_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    bus_reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask
endmodule

// [verif/tb_top.sv]
// self-checking bench for the backplane device bus slave
`timescale 1ns/1ps
`include "bpbus_defines.svh"
module tb_top;
  localparam int DEV = 5;
  localparam int MEM = 2;
  logic clk_sys, arst_n, op_done, alarm_event, oe_q, bus_read_write, bus_strobe_n;
  logic bus_reset_n, bus_data_oe, fast_alert_request_n, fast_alert_request_oe;
  logic board_fitted_n, board_fitted_oe;
  logic [9:0] bus_addr;
  logic [7:0] bus_data_in, bus_data_out, aux_status, control_out, v;
  logic [15:0] device_select_n;
  logic [3:0] memory_select_n;
  logic [7:0] exp_q[$];
  logic [7:0] mem_d[8];
  logic [9:0] mem_a[8];
  int err_total, n_tests, seed;

  // ****************
  // clock, checks and closing
  // ****************
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("%0d checks, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  bpbus_slave #(.DEV_ID(DEV), .MEM_ID(MEM)) DUT (.clk_sys(clk_sys), .arst_n(arst_n),
    .clk_en(1'b1), .bus_addr(bus_addr), .bus_data_in(bus_data_in),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .bus_read_write(bus_read_write),
    .bus_strobe_n(bus_strobe_n), .device_select_n(device_select_n),
    .memory_select_n(memory_select_n), .bus_reset_n(bus_reset_n),
    .fast_alert_request_n(fast_alert_request_n), .fast_alert_request_oe(fast_alert_request_oe),
    .board_fitted_n(board_fitted_n), .board_fitted_oe(board_fitted_oe), .op_done(op_done),
    .alarm_event(alarm_event), .aux_status(aux_status), .control_out(control_out));

  bpbus_master #(.DEV_ID(DEV), .MEM_ID(MEM)) u_mst (.clk_sys(clk_sys), .bus_addr(bus_addr),
    .bus_data_in(bus_data_in), .bus_read_write(bus_read_write), .bus_strobe_n(bus_strobe_n),
    .device_select_n(device_select_n), .memory_select_n(memory_select_n),
    .bus_reset_n(bus_reset_n));

  // reads are judged when the data enable rises, against the oldest note
  always @(negedge clk_sys)
  begin
    if (bus_data_oe === 1'b1 && oe_q !== 1'b1)
    begin
      check("read strobe", {7'h00, bus_read_write & ~bus_strobe_n}, 8'h01);
      if (exp_q.size() == 0)
        check("read count", 8'h01, 8'h00);
      else
        check("read data", bus_data_out, exp_q.pop_front());
    end
    if (device_select_n[DEV] === 1'b1 && bus_strobe_n === 1'b0)
      check("fitted idle", {7'h00, board_fitted_oe}, 8'h00);
    if (bus_data_oe === 1'b1 && device_select_n[DEV] === 1'b0)
      check("fitted", {board_fitted_oe, board_fitted_n, 6'h00}, 8'h80);
    oe_q <= bus_data_oe;
  end

  task automatic wr(input logic m, input logic f, input logic [9:0] a, input logic [7:0] d);
    u_mst.cycle(m, f, 1'b0, a, d);
  endtask

  task automatic rd(input logic m, input logic [9:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_mst.cycle(m, 1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic pulse(input logic alarm);
    @(negedge clk_sys);
    if (alarm)
      alarm_event = 1'b1;
    else
      op_done = 1'b1;
    @(negedge clk_sys);
    alarm_event = 1'b0;
    op_done = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic alert(input logic e);
    repeat (3) @(negedge clk_sys);
    check("alert", {fast_alert_request_oe, fast_alert_request_n, 6'h00}, {e, 7'h00});
  endtask

  // ****************
  // main sequence
  // ****************
  initial
  begin
    seed = 32'h3281d849;
    err_total = 0;
    n_tests = 0;
    arst_n = 1'b0;
    op_done = 1'b0;
    alarm_event = 1'b0;
    aux_status = 8'h00;
    repeat (10) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    check("control reset", control_out, `BPBUS_CTRL_RESET);
    rd(1'b0, `BPBUS_REG_STAT, 8'h00);
    repeat (4)
    begin
      v = 8'($random(seed));
      v[0] = 1'b0;
      wr(1'b0, 1'b0, `BPBUS_REG_CTRL, v);
      check("control", control_out, v);
      wr(1'b0, 1'b1, `BPBUS_REG_CTRL, ~v);
      check("foreign write", control_out, v);
      rd(1'b0, `BPBUS_REG_STAT, 8'h00);
    end
    // done with alerts disabled stays quiet until enabled
    wr(1'b0, 1'b0, `BPBUS_REG_CTRL, 8'h00);
    pulse(1'b0);
    alert(1'b0);
    wr(1'b0, 1'b0, `BPBUS_REG_CTRL, 8'h80);
    alert(1'b1);
    rd(1'b0, `BPBUS_REG_STAT, 8'h81);
    wr(1'b0, 1'b0, `BPBUS_REG_CTRL, 8'h81);
    alert(1'b0);
    rd(1'b0, `BPBUS_REG_STAT, 8'h00);
    wr(1'b0, 1'b0, `BPBUS_REG_CTRL, 8'h80);
    pulse(1'b1);
    rd(1'b0, `BPBUS_REG_STAT, 8'h82);
    wr(1'b0, 1'b0, `BPBUS_REG_CTRL, 8'h81);
    rd(1'b0, `BPBUS_REG_STAT, 8'h82);
    u_mst.bus_rst();
    rd(1'b0, `BPBUS_REG_STAT, 8'h00);
    alert(1'b0);
    aux_status = 8'($random(seed));
    rd(1'b0, `BPBUS_REG_AUX, aux_status);
    rd(1'b0, 10'h002, 8'h00);
    rd(1'b0, 10'h201, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      mem_a[i] = 10'(i * 8) + 10'($random(seed) & 7);
      mem_d[i] = 8'($random(seed));
      wr(1'b1, 1'b0, mem_a[i], mem_d[i]);
    end
    for (int i = 0; i < 8; i++)
      rd(1'b1, mem_a[i], mem_d[i]);
    for (int i = 0; i < 8; i++)
    begin
      wr(1'b1, 1'b0, mem_a[i], 8'h00);
      rd(1'b1, mem_a[i], 8'h00);
    end
    check("reads answered", 8'(exp_q.size()), 8'h00);
    finish_test();
  end

  // a hung handshake would otherwise stall the run
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end
endmodule
